// file: core/phy_strap_config_latch.sv
// Strap-in configuration latch captured at reset release
`timescale 1ns/100ps
// What this block does
// RULE1: The three address straps are sampled at reset release and give a management address of 0 to 7.
// RULE2: With no board resistors the internal pulls yield management address 00001.
// RULE3: The top two of the five address bits are always zero.
// RULE4: The three mode straps are captured at reset release.
// RULE5: Mode 001 is normal with crossover off, 101 back-to-back with crossover on, 111 normal with crossover on; others reserved.
// RULE6: Negotiation strap high (default) disables auto-negotiation, low enables it.
// RULE7: The captured negotiation strap loads control bit 12 at reset release, and software may override it later.
// RULE8: Interrupt-pin strap low at release enters NAND-tree test; high is normal.
// RULE9: Receive-error strap high at release disables the emission filter; low keeps it on.
// RULE10: Strap pins are pulled inputs only in reset and become outputs after release.
// RULE11: The board should add 4.7 kilohm pulls on straps shared with receive lines a MAC may drive in reset.
// RULE12: Latched values other than the negotiation bit hold until the next reset.
module phy_strap_config_latch (
  input  wire logic       clk_sys,                         // System clock, 100 MHz
  input  wire logic       reset,                           // Synchronous chip reset, active high
  input  wire logic       addr_strap_bit2_in,              // Address strap 2 pin input
  input  wire logic       addr_strap_bit1_in,              // Address strap 1 pin input
  input  wire logic       addr_strap_bit0_in,              // Address strap 0 pin input
  input  wire logic       mode_strap_bit2_in,              // Mode strap 2 pin input
  input  wire logic       mode_strap_bit1_in,              // Mode strap 1 pin input
  input  wire logic       mode_strap_bit0_in,              // Mode strap 0 pin input
  input  wire logic       negotiation_disable_strap_in,    // Negotiation strap pin input
  input  wire logic       irq_out_in,                      // Interrupt pin level, NAND-tree strap
  input  wire logic       emission_filter_disable_strap_in,// Receive-error pin level, filter strap
  input  wire logic [8:0] func_out,                        // Normal output levels, strap bit order
  input  wire logic       sw_neg_wr,                       // Software write strobe for control bit 12
  input  wire logic       sw_neg_val,                      // Value written to control bit 12
  output logic [8:0]      pin_out,                         // Pin output levels
  output logic [8:0]      pin_oe_n,                        // Pin output enables, low drives
  output logic [8:0]      pull_en,                         // Internal pull enables
  output logic [8:0]      pull_up,                         // Pull direction, high pulls up
  output logic [4:0]      mgmt_addr,                       // Management bus address
  output logic [2:0]      mode_code,                       // Latched mode code
  output logic            mode_reserved,                   // Mode code is a reserved value
  output logic            mode_back_to_back,               // Back-to-back interface selected
  output logic            crossover_en,                    // Automatic crossover enabled
  output logic            ctrl_neg_en,                     // Control bit 12, negotiation enable
  output logic            nand_tree_mode,                  // NAND-tree test mode active
  output logic            emission_filter_off,             // Emission filter disabled
  output logic            config_valid                     // Straps captured since reset
);
  strap_if sif ();

  logic [2:0]  addr_ff;
  logic [2:0]  mode_ff;
  logic        neg_bit_ff;
  logic        nand_ff;
  logic        filt_ff;
  logic        valid_ff;
  logic        in_reset_ff;
  logic        rsvd_ff;
  logic        b2b_ff;
  logic        xo_ff;
  logic [2:0]  nxt_addr;
  logic [2:0]  nxt_mode;
  logic        nxt_neg_bit;
  logic        nxt_nand;
  logic        nxt_filt;
  wire  [8:0]  raw_pins;
  wire         cap;
  wire  [2:0]  cap_mode;

  assign raw_pins = {emission_filter_disable_strap_in, irq_out_in, negotiation_disable_strap_in,
                     mode_strap_bit2_in, mode_strap_bit1_in, mode_strap_bit0_in,
                     addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in};

  strap_sync #(.W(strap_pkg::STRAP_W)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pins_in (raw_pins),
    .sif     (sif.src)
  );

  assign cap      = sif.capture;
  assign cap_mode = sif.straps[strap_pkg::POS_MODE2:strap_pkg::POS_MODE0];

  // Pins are pulled inputs while in reset, then driven with their normal function
  always_ff @(posedge clk_sys) begin
    in_reset_ff <= reset;
  end
  assign pull_en  = in_reset_ff ? 9'h1FF : 9'h000;                          // RULE10
  assign pull_up  = strap_pkg::PULL_DEFAULT;                                // RULE2
  assign pin_oe_n = in_reset_ff ? 9'h1FF : 9'h000;                          // RULE10
  assign pin_out  = func_out;

  // Next values: capture on the release strobe, otherwise hold
  assign nxt_addr = cap ? sif.straps[strap_pkg::POS_ADDR2:strap_pkg::POS_ADDR0] : addr_ff; // RULE1
  assign nxt_mode = cap ? cap_mode : mode_ff;                               // RULE4
  assign nxt_nand = cap ? ~sif.straps[strap_pkg::POS_NAND_N] : nand_ff;     // RULE8
  assign nxt_filt = cap ? sif.straps[strap_pkg::POS_FILT_DIS] : filt_ff;    // RULE9

  // Negotiation bit: strap high means disabled; software write wins after release
  always_comb begin
    nxt_neg_bit = neg_bit_ff;
    if (cap) begin
      nxt_neg_bit = ~sif.straps[strap_pkg::POS_NEG_DIS];                    // RULE6 RULE7
    end else if (sw_neg_wr && valid_ff) begin
      nxt_neg_bit = sw_neg_val;                                             // RULE7
    end
  end

  // Reset loads pull defaults so outputs are sane before capture
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_ff    <= strap_pkg::PULL_DEFAULT[strap_pkg::POS_ADDR2:strap_pkg::POS_ADDR0];
      mode_ff    <= strap_pkg::PULL_DEFAULT[strap_pkg::POS_MODE2:strap_pkg::POS_MODE0];
      neg_bit_ff <= ~strap_pkg::PULL_DEFAULT[strap_pkg::POS_NEG_DIS];
      nand_ff    <= ~strap_pkg::PULL_DEFAULT[strap_pkg::POS_NAND_N];
      filt_ff    <= strap_pkg::PULL_DEFAULT[strap_pkg::POS_FILT_DIS];
      valid_ff   <= 1'b0;
    end else begin
      addr_ff    <= nxt_addr;                                               // RULE12
      mode_ff    <= nxt_mode;                                               // RULE12
      neg_bit_ff <= nxt_neg_bit;
      nand_ff    <= nxt_nand;                                               // RULE12
      filt_ff    <= nxt_filt;                                               // RULE12
      valid_ff   <= valid_ff | cap;
    end
  end

  // Decode the code the mode register is about to take, so the registered
  // flags line up with mode_code both in reset and after capture
  wire [2:0] dec_code = reset ? strap_pkg::PULL_DEFAULT[strap_pkg::POS_MODE2:strap_pkg::POS_MODE0] : nxt_mode;
  wire is_b2b  = (dec_code == strap_pkg::MODE_B2B_XO);
  wire is_nxo  = (dec_code == strap_pkg::MODE_NORM_XO);
  wire is_norm = (dec_code == strap_pkg::MODE_NORMAL);

  // Decoded flags come from flip-flops; reserved codes select no interface mode
  always_ff @(posedge clk_sys) begin
    rsvd_ff <= ~(is_b2b | is_nxo | is_norm);                                // RULE5
    b2b_ff  <= is_b2b;                                                      // RULE5
    xo_ff   <= is_b2b | is_nxo;                                             // RULE5
  end

  assign mgmt_addr           = {strap_pkg::ADDR_HIGH_ZERO, addr_ff};        // RULE3
  assign mode_code           = mode_ff;
  assign mode_reserved       = rsvd_ff;                                     // RULE5
  assign mode_back_to_back   = b2b_ff;                                      // RULE5
  assign crossover_en        = xo_ff;                                       // RULE5
  assign ctrl_neg_en         = neg_bit_ff;
  assign nand_tree_mode      = nand_ff;
  assign emission_filter_off = filt_ff;
  assign config_valid        = valid_ff;
endmodule

// file: core/strap_if.sv
// Interface carrying the two-flop synchronised strap vector and reset edge
`timescale 1ns/100ps
interface strap_if;
  logic [strap_pkg::STRAP_W-1:0] straps;
  logic                          capture;
  modport src (output straps, output capture);
  modport dst (input straps, input capture);
endinterface

// file: core/strap_pkg.sv
// Package of strap positions, reset defaults and mode codes for the strap latch
package strap_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          MODE_W          = 3;
  localparam int          STRAP_W         = 9;
  // Strap vector bit positions
  localparam int          POS_ADDR0       = 0;
  localparam int          POS_ADDR2       = 2;
  localparam int          POS_MODE0       = 3;
  localparam int          POS_MODE2       = 5;
  localparam int          POS_NEG_DIS     = 6;
  localparam int          POS_NAND_N      = 7;
  localparam int          POS_FILT_DIS    = 8;
  // Internal pull levels: addr 001, mode pulls down, neg pull up, nand pull up, filter pull down
  localparam logic [8:0]  PULL_DEFAULT    = 9'h0C1;
  localparam logic [1:0]  ADDR_HIGH_ZERO  = 2'h0;
  localparam int          CTRL_NEG_BIT    = 12;
  typedef enum logic [2:0] {
    MODE_RSVD0    = 3'b000,
    MODE_NORMAL   = 3'b001,
    MODE_B2B_XO   = 3'b101,
    MODE_NORM_XO  = 3'b111
  } mode_code_t;
endpackage

// file: core/strap_sync.sv
// Two-flop synchroniser for strap pins plus reset-release capture strobe
`timescale 1ns/100ps
module strap_sync #(
  parameter int W = strap_pkg::STRAP_W
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         reset,     // Synchronous reset, active high
  input  wire logic [W-1:0] pins_in,   // Raw strap pin levels
  strap_if.src              sif        // Synchronised straps out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic         rst_d_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    meta_ff <= pins_in;
    sync_ff <= meta_ff;
  end

  // Remember reset so its falling edge can be seen
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rst_d_ff <= 1'b1;
    end else begin
      rst_d_ff <= 1'b0;
    end
  end

  assign sif.straps  = sync_ff;
  assign sif.capture = rst_d_ff & ~reset;
endmodule

// file: sim/strap_board.sv
// Board strap resistors on the strap pins
`timescale 1ns/100ps
module strap_board (
  input  wire logic [8:0] pin_out,   // Device output levels
  input  wire logic [8:0] pin_oe_n,  // Device drives when low
  input  wire logic [8:0] pull_en,   // Internal pulls on
  input  wire logic [8:0] pull_up,   // Internal pull direction
  input  wire logic [8:0] fit,       // Board resistor fitted
  input  wire logic [8:0] fit_up,    // Board resistor pulls up
  output logic      [8:0] level      // Resolved pin level
);
  // Driver beats board resistor, which beats the weak pull; a floating pin shows no stale value
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      level[i] = !pin_oe_n[i] ? pin_out[i] : fit[i] ? fit_up[i] : pull_en[i] ? pull_up[i] : ~pin_out[i];
    end
  end
endmodule

// file: sim/strap_latch_sva.sv
// Port checks of the strap latch, bound to its top module
`timescale 1ns/100ps
module strap_latch_sva (
  input wire logic       clk_sys,             // System clock
  input wire logic       reset,               // Synchronous reset, active high
  input wire logic       sw_neg_wr,           // Control bit write strobe
  input wire logic       sw_neg_val,          // Control bit write value
  input wire logic       mode_reserved,       // Reserved mode flag
  input wire logic       mode_back_to_back,   // Back-to-back flag
  input wire logic       crossover_en,        // Crossover flag
  input wire logic       ctrl_neg_en,         // Control bit 12
  input wire logic       nand_tree_mode,      // NAND-tree flag
  input wire logic       emission_filter_off, // Filter disable flag
  input wire logic       config_valid,        // Straps captured
  input wire logic [8:0] func_out,            // Normal output levels
  input wire logic [8:0] pin_out,             // Pin output levels
  input wire logic [8:0] pin_oe_n,            // Pin output enables
  input wire logic [8:0] pull_en,             // Pull enables
  input wire logic [8:0] pull_up,             // Pull directions
  input wire logic [4:0] mgmt_addr,           // Management address
  input wire logic [2:0] mode_code            // Latched mode code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Latched fields must not follow the pins once they turn into outputs
  a_addr_top_zero: assert property (mgmt_addr[4:3] == 2'h0) else $error("address top bits set");
  a_cfg_held: assert property (config_valid && $past(config_valid) |->
    $stable({mgmt_addr, mode_code, nand_tree_mode, emission_filter_off})) else $error("latched config moved");
  a_pins_live: assert property (config_valid |-> pin_oe_n == 9'h000 && pull_en == 9'h000)
    else $error("pins not released");
  a_pins_held_in: assert property ($rose(config_valid) |-> $past(pin_oe_n) == 9'h1FF && $past(pull_en) == 9'h1FF)
    else $error("pins driven before capture");
  a_pin_follow: assert property (pin_out == func_out) else $error("pin level not function level");
  a_pull_dir: assert property (pull_up == 9'h0C1) else $error("pull direction wrong");
  a_mode_decode: assert property (mode_reserved == !(mode_code inside {3'h1, 3'h5, 3'h7}) &&
    crossover_en == (mode_code inside {3'h5, 3'h7}) && mode_back_to_back == (mode_code == 3'h5))
    else $error("mode decode wrong");
  a_neg_write: assert property (config_valid && sw_neg_wr |=> ctrl_neg_en == $past(sw_neg_val))
    else $error("control bit write lost");
  a_neg_keep: assert property (config_valid && !sw_neg_wr |=> $stable(ctrl_neg_en))
    else $error("control bit moved");
endmodule
bind phy_strap_config_latch strap_latch_sva u_sva (.*);

// file: sim/tb_phy_strap_config_latch.sv
// Self-checking bench for the strap latch
`timescale 1ns/100ps
module tb_phy_strap_config_latch;
  logic       clk_sys = 1'b0, reset = 1'b1, sw_neg_wr = 1'b0, sw_neg_val = 1'b0;
  logic [8:0] func_out = 9'h000, fit = 9'h000, fit_up = 9'h000, level, pin_out, pin_oe_n, pull_en, pull_up;
  logic [4:0] mgmt_addr;
  logic [2:0] mode_code;
  logic       mode_reserved, mode_back_to_back, crossover_en, ctrl_neg_en, nand_tree_mode, emission_filter_off, cfg_ok;
  int         error_cnt = 0, check_count = 0, seed = 40, cycles = 0, p, m, neg;
  always #5 clk_sys = ~clk_sys;
  strap_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en), .pull_up(pull_up),
    .fit(fit), .fit_up(fit_up), .level(level));
  phy_strap_config_latch DUT (.clk_sys(clk_sys), .reset(reset), .addr_strap_bit2_in(level[2]),
    .addr_strap_bit1_in(level[1]), .addr_strap_bit0_in(level[0]), .mode_strap_bit2_in(level[5]),
    .mode_strap_bit1_in(level[4]), .mode_strap_bit0_in(level[3]), .negotiation_disable_strap_in(level[6]),
    .irq_out_in(level[7]), .emission_filter_disable_strap_in(level[8]), .func_out(func_out),
    .sw_neg_wr(sw_neg_wr), .sw_neg_val(sw_neg_val), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
    .pull_up(pull_up), .mgmt_addr(mgmt_addr), .mode_code(mode_code), .mode_reserved(mode_reserved),
    .mode_back_to_back(mode_back_to_back), .crossover_en(crossover_en), .ctrl_neg_en(ctrl_neg_en),
    .nand_tree_mode(nand_tree_mode), .emission_filter_off(emission_filter_off), .config_valid(cfg_ok));
  task automatic chk(input string name, input int exp, input logic [8:0] got);
    check_count++;
    if (got !== 9'(exp)) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Round 0 leaves straps to the internal pulls; later rounds force every mode code
  task automatic round(input int k);
    reset = 1'b1;
    fit = (k == 0) ? 9'h000 : 9'($random(seed)) | 9'h038;
    fit_up = 9'($random(seed));
    fit_up[5:3] = 3'(k);
    repeat ((k == 0) ? 16 : 4) @(posedge clk_sys);
    #1 chk("pins_in_reset", 9'h1FF, pin_oe_n & pull_en);
    chk("config_valid", 0, 9'(cfg_ok));
    reset = 1'b0;
    func_out = 9'($random(seed));
    p = (fit & fit_up) | (~fit & 9'h0C1);
    m = (p >> 3) & 7;
    neg = ((p >> 6) & 1) ^ 1;
    repeat (2) @(posedge clk_sys);
    #1 chk("mgmt_addr", p & 7, 9'(mgmt_addr));
    chk("mode_code", m, 9'(mode_code));
    chk("decode", (!(m == 1 || m == 5 || m == 7)) * 4 + (m == 5) * 2 + (m == 5 || m == 7), 9'({mode_reserved, mode_back_to_back, crossover_en}));
    chk("nand_tree_mode", ((p >> 7) & 1) ^ 1, 9'(nand_tree_mode));
    chk("emission_filter_off", (p >> 8) & 1, 9'(emission_filter_off));
    chk("pin_oe_n", 0, pin_oe_n | pull_en);
    chk("config_valid", 1, 9'(cfg_ok));
    chk("pin_out", func_out, pin_out);
    chk("ctrl_neg_en", neg, 9'(ctrl_neg_en));
    for (int i = 0; i < 6; i++) begin
      sw_neg_wr = 1'($random(seed));
      sw_neg_val = 1'($random(seed));
      func_out = 9'($random(seed));
      if (sw_neg_wr) neg = sw_neg_val;
      @(posedge clk_sys);
      #1 chk("ctrl_neg_en", neg, 9'(ctrl_neg_en));
    end
    sw_neg_wr = 1'b0;
    chk("held", (m << 3) | (p & 7), 9'({mode_code, mgmt_addr[2:0]}));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    for (int k = 0; k < 9; k++) round(k);
    results();
  end
endmodule
